// ### dv/bhc_dbg_model.sv
`default_nettype none

module bhc_dbg_model
  import bhc_pkg::*;
(
  // Clock
  input  wire logic        core_clk,
  // Register port
  output logic [7:0]       reg_addr,
  output logic [31:0]      reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    reg_addr  = 8'hff;
    reg_wdata = 32'hffffffff;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // Idle bus shows the inverse of the last value, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= dat;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~dat;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dat);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge core_clk);
    dat = reg_rdata;
  endtask

  // Code restore and line invalidate happen in memory before this
  task automatic resume(input logic [31:0] pc, input logic five,
                        input logic ub_bit);
    wr(BHC_OFS_PC, five ? pc - 32'h2 : pc);
    wr(BHC_OFS_DEBUG, {29'h0, ub_bit, 2'h0});
  endtask
endmodule // bhc_dbg_model

`default_nettype wire

// ### dv/bhc_halt_ctl_properties.sv
`default_nettype none

module bhc_chk
  import bhc_pkg::*;
#(
  parameter logic [1:0] MODE = BHC_MODE_KERNEL
)
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  // Register port
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [31:0]   reg_rdata,
  // Pipeline
  input  wire bhc_pipe_in_t  pipe_in,
  input  wire bhc_pipe_ctl_t pipe_ctl
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_brk;
    MODE == BHC_MODE_KERNEL && !pipe_ctl.halted && !reg_wr &&
    pipe_in.s1_valid && pipe_in.kernel_mode &&
    (pipe_in.s1_brk_long || pipe_in.s1_brk_short);
  endsequence

  sequence s_take;
    s_brk ##0 !pipe_in.flagw_halt;
  endsequence

  property p_halt;
    s_take |=> pipe_ctl.halted && pipe_ctl.bh && pipe_ctl.stall_s1 &&
      pipe_ctl.stall_s2 && pipe_ctl.flush_front;
  endproperty
  a_halt: assert property (p_halt)
    else $error("breakpoint did not halt");

  property p_pc;
    s_take |=> pipe_ctl.pc == $past(pipe_in.s1_pc);
  endproperty
  a_pc: assert property (p_pc)
    else $error("halted pc wrong");

  property p_irq;
    s_take ##0 (pipe_in.irq_req || (pipe_in.s1_brk_short && pipe_in.s2_irq))
      |=> pipe_ctl.irq_hold;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not held");

  property p_link;
    s_take ##0 (pipe_in.s1_brk_short && pipe_in.s2_link)
      |=> pipe_ctl.link_hold;
  endproperty
  a_link: assert property (p_link)
    else $error("link write not deferred");

  property p_s3;
    s_take ##0 pipe_in.s3_irq |=> pipe_ctl.keep_s3;
  endproperty
  a_s3: assert property (p_s3)
    else $error("stage three interrupt not kept");

  property p_flagw;
    s_brk ##0 pipe_in.flagw_halt |=> pipe_ctl.halted && !pipe_ctl.bh;
  endproperty
  a_flagw: assert property (p_flagw)
    else $error("flag write did not go first");

  property p_bh_clr;
    $fell(pipe_ctl.halted) |-> !pipe_ctl.bh;
  endproperty
  a_bh_clr: assert property (p_bh_clr)
    else $error("breakpoint flag outlived halt");

  property p_stay;
    pipe_ctl.halted && !(reg_wr && reg_addr == BHC_OFS_DEBUG)
      |=> pipe_ctl.halted;
  endproperty
  a_stay: assert property (p_stay)
    else $error("halt dropped without restart");

  property p_fault;
    pipe_ctl.fault |-> !pipe_ctl.halted;
  endproperty
  a_fault: assert property (p_fault)
    else $error("denied breakpoint halted");

  property p_refetch;
    pipe_ctl.refetch |-> $fell(pipe_ctl.halted);
  endproperty
  a_refetch: assert property (p_refetch)
    else $error("refetch outside restart");
endmodule // bhc_chk

bind bhc_halt_ctl bhc_chk #(.MODE(MODE)) i_bhc_chk (
  .core_clk  (core_clk),
  .rst_n     (rst_n),
  .reg_addr  (reg_addr),
  .reg_wdata (reg_wdata),
  .reg_wr    (reg_wr),
  .reg_rd    (reg_rd),
  .reg_rdata (reg_rdata),
  .pipe_in   (pipe_in),
  .pipe_ctl  (pipe_ctl)
);

`default_nettype wire

// ### dv/tb.sv
`default_nettype none

module tb
  import bhc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic          core_clk;
  logic          rst_n;
  logic [7:0]    reg_addr;
  logic [31:0]   reg_wdata;
  logic          reg_wr;
  logic          reg_rd;
  logic [31:0]   reg_rdata;
  bhc_pipe_in_t  pipe_in;
  bhc_pipe_ctl_t pipe_ctl;
  bhc_pipe_in_t  p;
  bhc_pipe_ctl_t e;
  int            errors;
  int            comparisons;
  int            cycles;
  logic [31:0]   seed;
  logic [31:0]   r;
  logic          user_en;
  logic          fault_m;
  bhc_pipe_in_t  pipe_alt;
  bhc_pipe_ctl_t ctl_four;
  bhc_pipe_ctl_t ctl_five;

  bhc_halt_ctl #(.MODE(BHC_MODE_KERNEL)) i_bhc_halt_ctl (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pipe_in(pipe_in), .pipe_ctl(pipe_ctl));

  bhc_dbg_model i_bhc_dbg_model (
    .core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // Four- and five-stage cores share the bus and also share one pipe of their own, pipe_alt
  bhc_halt_ctl #(.MODE(BHC_MODE_FOUR)) i_bhc_halt_ctl_four (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(), .pipe_in(pipe_alt), .pipe_ctl(ctl_four));

  bhc_halt_ctl #(.MODE(BHC_MODE_FIVE)) i_bhc_halt_ctl_five (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(), .pipe_in(pipe_alt), .pipe_ctl(ctl_five));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_ctl(input bhc_pipe_ctl_t got, input bhc_pipe_ctl_t exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t ctl %h expected %h", $time, got, exp);
    end
  endtask

  task automatic fire(input bhc_pipe_in_t pi);
    @(posedge core_clk);
    pipe_in <= pi;
    @(posedge core_clk);
    pipe_in <= '0;
    #1;
  endtask

  task automatic settle(input logic [31:0] pc, input logic exp_flag);
    r = '0;
    for (int n = 0; n < 8 && r[5:4] !== 2'h2; n++)
      i_bhc_dbg_model.rd(BHC_OFS_STATUS, r);
    chk(r, 32'h24);
    i_bhc_dbg_model.rd(BHC_OFS_DEBUG, r);
    chk(r, {29'h0, user_en, exp_flag, 1'b1});
    i_bhc_dbg_model.resume(pc, 1'b0, user_en);
    #1;
    chk({25'h0, pipe_ctl.halted, pipe_ctl.bh, pipe_ctl.stall_s1,
         pipe_ctl.stall_s2, pipe_ctl.link_hold, pipe_ctl.refetch,
         pipe_ctl.flush_front}, 32'h3);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      print_verdict();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    pipe_in = '0;
    pipe_alt = '0;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    seed = 32'he86bf386;
    user_en = 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    i_bhc_dbg_model.rd(BHC_OFS_DEBUG, r);
    chk(r, 32'h0);
    i_bhc_dbg_model.rd(BHC_OFS_STATUS, r);
    chk(r, 32'h4);
    i_bhc_dbg_model.rd(8'h0c, r);
    chk(r, 32'h0);
    // User-mode breakpoint without enable is refused
    p = '0;
    p.s1_valid = 1'b1;
    p.s1_brk_long = 1'b1;
    fire(p);
    chk({30'h0, pipe_ctl.fault, pipe_ctl.halted}, 32'h2);
    fault_m = 1'b1;
    i_bhc_dbg_model.rd(BHC_OFS_STATUS, r);
    chk(r, {31'h2, fault_m});
    i_bhc_dbg_model.wr(BHC_OFS_STATUS, 32'h1);
    fault_m = 1'b0;
    i_bhc_dbg_model.rd(BHC_OFS_STATUS, r);
    chk(r, {31'h2, fault_m});
    for (int i = 0; i < 6; i++)
    begin
      if (i == 4)
      begin
        i_bhc_dbg_model.wr(BHC_OFS_DEBUG, 32'h4);
        user_en = 1'b1;
      end
      r = rnd();
      p = '0;
      p.s1_valid = 1'b1;
      p.s1_brk_long = ~i[0];
      p.s1_brk_short = i[0];
      p.kernel_mode = (i < 4);
      p.irq_req = r[0];
      p.s2_irq = r[1];
      p.s2_link = r[2];
      p.s3_irq = r[3];
      p.s1_after_branch = r[4];
      p.stage_busy = r[9:5];
      p.s1_pc = rnd();
      fire(p);
      e = '0;
      e.stall_s1 = 1'b1;
      e.stall_s2 = 1'b1;
      e.flush_front = 1'b1;
      e.flag_hold = 1'b1;
      e.halted = 1'b1;
      e.bh = 1'b1;
      e.pc = p.s1_pc;
      e.keep_s3 = p.s3_irq;
      e.irq_hold = p.irq_req | (i[0] & p.s2_irq);
      e.link_hold = i[0] & p.s2_link;
      chk_ctl(pipe_ctl, e);
      settle(p.s1_pc, 1'b1);
    end
    p.flagw_halt = 1'b1;
    p.kernel_mode = 1'b1;
    fire(p);
    chk({30'h0, pipe_ctl.halted, pipe_ctl.bh}, 32'h2);
    settle(p.s1_pc, 1'b0);
    // Plain code: no loop end, no halting flag-write close
    for (int j = 0; j < 2; j++)
    begin
      r = rnd();
      p = '0;
      p.s1_valid = 1'b1;
      p.s1_brk_short = 1'b1;
      p.s2_valid = 1'b1;
      // Five-stage never sees a breakpoint behind a branch
      p.s2_brk = ~j[0];
      // Plain branch only, never a compare-branch
      p.s1_after_branch = j[0];
      p.irq_req = r[0];
      p.s2_irq = r[1];
      p.s2_link = r[2];
      p.s3_irq = r[3];
      p.s1_pc = rnd();
      @(posedge core_clk);
      pipe_alt <= p;
      @(posedge core_clk);
      pipe_alt <= '0;
      #1;
      e = '0;
      e.stall_s1 = 1'b1;
      e.stall_s2 = p.s1_after_branch;
      e.flush_front = 1'b1;
      e.flag_hold = 1'b1;
      e.halted = 1'b1;
      e.bh = 1'b1;
      e.pc = p.s1_pc;
      e.keep_s3 = p.s3_irq;
      e.irq_hold = p.irq_req | p.s2_irq;
      e.link_hold = p.s2_link;
      chk_ctl(ctl_four, e);
      if (j == 0)
      begin
        e.stall_s2 = 1'b1;
        chk_ctl(ctl_five, e);
      end
      i_bhc_dbg_model.resume(p.s1_pc, ~j[0], user_en);
      #1;
      chk(ctl_four.pc, p.s1_pc - (j[0] ? 32'h0 : 32'h2));
      chk({29'h0, ctl_four.halted, ctl_four.bh, ctl_four.refetch},
          32'h1);
    end
    print_verdict();
  end
endmodule // tb

`default_nettype wire

// ### logic/bhc_drain.sv
`default_nettype none

module bhc_drain
  import bhc_pkg::*;
#(
  parameter int N = BHC_STAGES
)
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Stage occupancy
  input  wire logic [N:1]   busy,
  input  wire logic [N:1]   mask,
  // Result
  output logic              drained
);

  typedef struct packed {
    logic empty;
  } bhc_drain_t;

  bhc_drain_t r;
  bhc_drain_t next_r;

  // Registered so the halt decision sees a settled view
  always_comb
  begin
    next_r       = r;
    next_r.empty = ~|(busy & mask);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign drained = r.empty;

endmodule // bhc_drain

`default_nettype wire

// ### logic/bhc_halt_ctl.sv
`default_nettype none

module bhc_halt_ctl
  import bhc_pkg::*;
#(
  parameter logic [1:0] MODE = BHC_MODE_KERNEL
)
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  // Register port
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [31:0]        reg_rdata,
  // Pipeline
  input  wire bhc_pipe_in_t  pipe_in,
  output bhc_pipe_ctl_t      pipe_ctl
);

  bhc_regs_t  r;
  bhc_regs_t  next_r;

  logic       is_kernel;
  logic       brk_s1;
  logic       brk_seen;
  logic       brk_ok;
  logic       brk_denied;
  logic       short_s1;
  logic       flagw_first;
  logic       wr_dbg;
  logic       wr_pc;
  logic       wr_stat;
  logic       halt_set_req;
  logic       halt_clr_req;
  logic       drained;
  logic [5:1] drain_mask;

  assign is_kernel = (MODE == BHC_MODE_KERNEL);

  // Breakpoint visible in stage one, either encoding
  assign brk_s1 = pipe_in.s1_valid
                & (pipe_in.s1_brk_long | pipe_in.s1_brk_short); // [RULE16]

  assign short_s1 = pipe_in.s1_valid & pipe_in.s1_brk_short;

  // Where the breakpoint is decoded depends on the pipe shape
  always_comb
  begin
    case (MODE)
      BHC_MODE_FOUR:
      begin
        brk_seen   = brk_s1; // [RULE4]
        drain_mask = BHC_DRAIN_FOUR;
      end
      BHC_MODE_FIVE:
      begin
        brk_seen   = pipe_in.s2_valid & pipe_in.s2_brk; // [RULE5]
        drain_mask = BHC_DRAIN_FIVE;
      end
      BHC_MODE_KERNEL:
      begin
        brk_seen   = brk_s1; // [RULE17] [RULE18]
        drain_mask = BHC_DRAIN_KERNEL;
      end
      default:
      begin
        brk_seen   = 1'b0;
        drain_mask = BHC_DRAIN_KERNEL;
      end
    endcase
  end

  // Kernel config: user-mode breakpoint needs the enable bit
  assign brk_ok = brk_seen
                & (~is_kernel | pipe_in.kernel_mode | r.ub); // [RULE15]
  assign brk_denied = brk_seen & ~brk_ok;

  // Kernel config: a halting flag-write ahead of a breakpoint is taken first
  assign flagw_first = is_kernel & pipe_in.flagw_halt; // [RULE19]

  assign wr_dbg  = reg_wr & (reg_addr == BHC_OFS_DEBUG);
  assign wr_pc   = reg_wr & (reg_addr == BHC_OFS_PC);
  assign wr_stat = reg_wr & (reg_addr == BHC_OFS_STATUS);

  assign halt_set_req = wr_dbg & reg_wdata[BHC_BIT_HALT];
  assign halt_clr_req = wr_dbg & ~reg_wdata[BHC_BIT_HALT];

  bhc_drain #(
    .N (BHC_STAGES)
  ) u_drain (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .busy     (pipe_in.stage_busy),
    .mask     (drain_mask),
    .drained  (drained)
  );

  always_comb
  begin
    next_r             = r;
    next_r.ctl.refetch = 1'b0;
    next_r.ctl.fault   = 1'b0;
    next_r.rdata       = '0;

    if (wr_dbg)
    begin
      next_r.ub = reg_wdata[BHC_BIT_UB];
    end

    case (r.st)
      BHC_RUN:
      begin
        if (flagw_first)
        begin
          // Flag-write halts and flushes; breakpoint never runs
          next_r.ctl.halted      = 1'b1; // [RULE19]
          next_r.ctl.stall_s1    = 1'b1;
          next_r.ctl.stall_s2    = 1'b1;
          next_r.ctl.flush_front = 1'b1;
          next_r.ctl.pc          = pipe_in.s1_pc;
          next_r.st              = BHC_DRAIN;
        end
        else if (brk_ok)
        begin
          // Stop issue past the breakpoint and drain the rest
          next_r.ctl.flush_front = 1'b1; // [RULE1]
          next_r.ctl.stall_s1    = 1'b1; // [RULE4]
          next_r.ctl.stall_s2    = (MODE != BHC_MODE_FOUR)
                                 | pipe_in.s1_after_branch; // [RULE5] [RULE9]
          next_r.ctl.halted      = 1'b1; // [RULE2]
          next_r.ctl.bh          = 1'b1; // [RULE2]
          next_r.ctl.flag_hold   = 1'b1; // [RULE2]
          next_r.ctl.irq_hold    = pipe_in.irq_req // [RULE12]
                                 | (short_s1 & pipe_in.s2_irq); // [RULE11]
          next_r.ctl.keep_s3     = pipe_in.s3_irq; // [RULE13]
          next_r.ctl.link_hold   = short_s1
                                 & pipe_in.s2_link; // [RULE10]
          // Own address in stage one, next address in five-stage
          next_r.ctl.pc          = pipe_in.s1_pc; // [RULE5] [RULE17]
          next_r.st              = BHC_DRAIN;
        end
        else if (halt_set_req)
        begin
          next_r.ctl.halted      = 1'b1;
          next_r.ctl.stall_s1    = 1'b1;
          next_r.ctl.stall_s2    = 1'b1;
          next_r.ctl.flush_front = 1'b1;
          next_r.ctl.pc          = pipe_in.s1_pc;
          next_r.st              = BHC_DRAIN;
        end
        else
        begin
          next_r.ctl.stall_s1    = 1'b0;
          next_r.ctl.stall_s2    = 1'b0;
          next_r.ctl.flush_front = 1'b0;
        end
      end

      BHC_DRAIN:
      begin
        // Later stages keep running until they are empty
        if (drained)
        begin
          next_r.ctl.keep_s3 = 1'b0; // [RULE13]
          next_r.st          = BHC_HALTED;
        end
      end

      BHC_HALTED:
      begin
        if (wr_pc)
        begin
          next_r.ctl.pc  = reg_wdata;
          next_r.pc_dirty = 1'b1; // [RULE21]
        end
        if (halt_clr_req)
        begin
          // Restart: both flags drop together
          next_r.ctl.halted      = 1'b0; // [RULE3]
          next_r.ctl.bh          = 1'b0; // [RULE3]
          next_r.ctl.stall_s1    = 1'b0;
          next_r.ctl.stall_s2    = 1'b0;
          next_r.ctl.irq_hold    = 1'b0;
          next_r.ctl.flag_hold   = 1'b0;
          // Deferred link write now goes ahead
          next_r.ctl.link_hold   = 1'b0; // [RULE10]
          // Discard stale fetches if the pc was rewritten
          next_r.ctl.flush_front = r.pc_dirty | wr_pc; // [RULE21]
          next_r.ctl.refetch     = r.pc_dirty | wr_pc; // [RULE21]
          next_r.pc_dirty        = 1'b0;
          next_r.st              = BHC_RUN;
        end
      end

      default:
      begin
        next_r = BHC_REGS_RESET;
      end
    endcase

    // Sticky fault: set wins over a clear in the same cycle
    if (wr_stat & reg_wdata[BHC_BIT_FAULT])
    begin
      next_r.fault_sticky = 1'b0;
    end
    if (brk_denied & (r.st == BHC_RUN) & ~flagw_first)
    begin
      next_r.ctl.fault    = 1'b1; // [RULE15]
      next_r.fault_sticky = 1'b1;
    end

    if (reg_rd)
    begin
      case (reg_addr)
        BHC_OFS_DEBUG:
        begin
          next_r.rdata[BHC_BIT_HALT] = r.ctl.halted;
          next_r.rdata[BHC_BIT_BH]   = r.ctl.bh;
          next_r.rdata[BHC_BIT_UB]   = r.ub;
        end
        BHC_OFS_PC:
        begin
          next_r.rdata = r.ctl.pc;
        end
        BHC_OFS_STATUS:
        begin
          next_r.rdata[BHC_BIT_FAULT] = r.fault_sticky;
          next_r.rdata[BHC_POS_MODE +: 2]  = MODE;
          next_r.rdata[BHC_POS_STATE +: 2] = r.st;
        end
        default:
        begin
          next_r.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= BHC_REGS_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign pipe_ctl  = r.ctl;
  assign reg_rdata = r.rdata;

endmodule // bhc_halt_ctl

`default_nettype wire

// ### shared/bhc_pkg.sv
// Summary of operation
// RULE1: Breakpoint stops issue and flushes pipeline
// RULE2: Breakpoint sets halt flags, condition flags kept
// RULE3: Clearing halt also clears breakpoint-halt flag
// RULE4: Four-stage: decode stage one, drain later
// RULE5: Five-stage: decode stage two, pc next
// RULE6: Debugger subtracts two from five-stage pc
// RULE7: No breakpoint right after listed branches
// RULE8: No breakpoint ending a zero-overhead loop
// RULE9: After branch, stall stages one and two
// RULE10: Short breakpoint after link defers link write
// RULE11: Interrupt in stage two held, rest flushed; code holds it only behind a short breakpoint in stage one
// RULE12: Same-cycle interrupt loses to breakpoint
// RULE13: Interrupt in stage three may complete
// RULE14: Halt flag-write needs three following no-ops
// RULE15: Kernel config: user breakpoint needs enable
// RULE16: Kernel config: long and short encodings
// RULE17: Kernel config: pc equals breakpoint address
// RULE18: Kernel config: breakpoint legal anywhere
// RULE19: Kernel config: halting flag-write goes first
// RULE20: Debugger restores code, invalidates, rewrites pc
// RULE21: Pc write while halted refetches on restart
`default_nettype none

package bhc_pkg;

  localparam logic [1:0] BHC_MODE_FOUR   = 2'h0;
  localparam logic [1:0] BHC_MODE_FIVE   = 2'h1;
  localparam logic [1:0] BHC_MODE_KERNEL = 2'h2;

  localparam int BHC_STAGES = 5;

  localparam logic [7:0] BHC_OFS_DEBUG  = 8'h00;
  localparam logic [7:0] BHC_OFS_PC     = 8'h04;
  localparam logic [7:0] BHC_OFS_STATUS = 8'h08;

  localparam int BHC_BIT_HALT  = 0;
  localparam int BHC_BIT_BH    = 1;
  localparam int BHC_BIT_UB    = 2;
  localparam int BHC_BIT_FAULT = 0;
  localparam int BHC_POS_MODE  = 1;
  localparam int BHC_POS_STATE = 4;

  localparam logic [5:1] BHC_DRAIN_FOUR   = 5'h0e;
  localparam logic [5:1] BHC_DRAIN_FIVE   = 5'h1c;
  localparam logic [5:1] BHC_DRAIN_KERNEL = 5'h1e;

  typedef enum logic [1:0] {
    BHC_RUN,
    BHC_DRAIN,
    BHC_HALTED
  } bhc_state_t;

  typedef struct packed {
    logic        s1_valid;
    logic        s1_brk_long;
    logic        s1_brk_short;
    logic        s1_after_branch;
    logic [31:0] s1_pc;
    logic        s2_valid;
    logic        s2_brk;
    logic        s2_link;
    logic        s2_irq;
    logic        s3_irq;
    logic        irq_req;
    logic        flagw_halt;
    logic        kernel_mode;
    logic [5:1]  stage_busy;
  } bhc_pipe_in_t;

  typedef struct packed {
    logic        stall_s1;
    logic        stall_s2;
    logic        flush_front;
    logic        keep_s3;
    logic        irq_hold;
    logic        link_hold;
    logic        flag_hold;
    logic        refetch;
    logic        halted;
    logic        bh;
    logic        fault;
    logic [31:0] pc;
  } bhc_pipe_ctl_t;

  typedef struct packed {
    bhc_state_t    st;
    logic          ub;
    logic          pc_dirty;
    logic          fault_sticky;
    logic [31:0]   rdata;
    bhc_pipe_ctl_t ctl;
  } bhc_regs_t;

  localparam bhc_regs_t BHC_REGS_RESET = '0;

endpackage

`default_nettype wire
